// file: hdl/serial_ctrl_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef SERIAL_CTRL_MAP_SVH
`define SERIAL_CTRL_MAP_SVH
`define OFS_SERIAL_DATA      16'hC83C
`define OFS_SPI_STATUS       16'hC840
`define OFS_TWO_WIRE_STATUS  16'hC844
`define OFS_TWO_WIRE_COMMAND 16'hC84C
`define OFS_TWO_WIRE_ACK     16'hC850
`define OFS_SPI_CONFIG       16'hC858
`define OFS_CLOCK_LINEAR     16'hC860
`define OFS_CLOCK_EXPONENT   16'hC864
`define OFS_MODE_SELECT      16'hC868
`define CFG_RX_DRIVEN        5
`define CFG_MASTER           4
`define CFG_REPEAT           3
`define CFG_ORDER            2
`define CFG_PHASE            1
`define CFG_POLARITY         0
`define CMD_STOP             3
`define CMD_START            2
`define CMD_SEND             1
`define CMD_RECV             0
`define REG_RESET            32'h0000_0000
`define BUSY_TOKEN           8'hFF
`define BASE_RATE_MHZ        12
`define SYS_RATE_MHZ         200
// Half-period tick runs at twice the base rate, cycle count rounded down
`define BASE_TICK_CYCLES     (`SYS_RATE_MHZ / (2 * `BASE_RATE_MHZ))
`endif

// file: hdl/serial_ctrl_pkg.sv
// Types shared by the serial controller
package serial_ctrl_pkg;
  typedef struct packed {
    logic       rx_driven_select;
    logic       master_select;
    logic       underrun_repeat_select;
    logic       bit_order_select;
    logic       clock_phase_select;
    logic       clock_polarity_select;
  } spi_cfg_t;
  typedef struct packed {
    logic command_finished_flag;
    logic receive_finished_flag;
    logic transmit_finished_flag;
    logic nack_received_flag;
  } twi_stat_t;
  typedef enum logic [5:0] {
    TW_IDLE  = 6'b000001,
    TW_START = 6'b000010,
    TW_STOP  = 6'b000100,
    TW_BYTE  = 6'b001000,
    TW_ACK   = 6'b010000,
    TW_DONE  = 6'b100000
  } twi_state_t;
endpackage

// file: hdl/serial_ctrl.sv
// Serial controller: SPI master/slave and two-wire master sequencer
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`include "serial_ctrl_map.svh"
module serial_ctrl
  import serial_ctrl_pkg::*;
#(
  parameter int FIFO_DEPTH = 4
) (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  input  wire logic        clk_en_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  input  wire logic        sck_i,
  output logic             sck_o,
  output logic             sck_oe_o,
  output logic             mosi_o,
  output logic             mosi_oe_o,
  input  wire logic        miso_i,
  output logic             miso_o,
  output logic             miso_oe_o,
  input  wire logic        mosi_i,
  input  wire logic        sel_n_i,
  input  wire logic        scl_i,
  output logic             scl_oe_o,
  input  wire logic        sda_i,
  output logic             sda_oe_o
);
  localparam int PW = $clog2(FIFO_DEPTH);
  if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_bad
    $error("FIFO_DEPTH must be a power of two of at least 2");
  end

  //////////////////////////////////////////////////////////////////////////
  // Register file
  spi_cfg_t   cfg_ff;
  logic       twi_mode_ff;
  logic [3:0] lin_ff;
  logic [3:0] exp_ff;
  logic [3:0] cmd_ff;
  logic       ack_ctl_ff;
  twi_stat_t  tw_stat_ff;
  logic       ovf_ff;
  logic       repeat_eff_ff;
  logic       wr_data;
  logic       rd_data;
  assign wr_data = clk_en_i && wr_i && addr_i == `OFS_SERIAL_DATA;
  assign rd_data = clk_en_i && rd_i && addr_i == `OFS_SERIAL_DATA;

  // FIFOs
  logic [7:0]  txq [FIFO_DEPTH];
  logic [7:0]  rxq [FIFO_DEPTH];
  logic [PW:0] tx_wp_ff, tx_rp_ff, rx_wp_ff, rx_rp_ff;
  logic        tx_empty, tx_full, rx_empty, rx_full;
  logic        tx_pop, rx_push;
  logic [7:0]  rx_byte;
  assign tx_empty = tx_wp_ff == tx_rp_ff;
  assign tx_full  = (tx_wp_ff - tx_rp_ff) == (PW+1)'(FIFO_DEPTH);
  assign rx_empty = rx_wp_ff == rx_rp_ff;
  assign rx_full  = (rx_wp_ff - rx_rp_ff) == (PW+1)'(FIFO_DEPTH);

  // Shifter
  logic       busy_ff;
  logic [7:0] sh_out_ff, sh_in_ff, last_ff;
  logic [3:0] bit_cnt_ff;
  logic       phase_ff;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_ff      <= '0;
      twi_mode_ff <= 1'b0;
      lin_ff      <= 4'h0;
      exp_ff      <= 4'h0;
      ack_ctl_ff  <= 1'b0;
    end else if (clk_en_i && wr_i) begin
      case (addr_i)
        `OFS_SPI_CONFIG:     cfg_ff      <= spi_cfg_t'(wdata_i[5:0]);
        `OFS_CLOCK_LINEAR:   lin_ff      <= wdata_i[3:0];
        `OFS_CLOCK_EXPONENT: exp_ff      <= wdata_i[3:0];
        `OFS_TWO_WIRE_ACK:   ack_ctl_ff  <= wdata_i[0];
        `OFS_MODE_SELECT:    twi_mode_ff <= wdata_i[0];
        default: ;
      endcase
    end
  end

  // Repeat setting latched only while idle and drained
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i)
      repeat_eff_ff <= 1'b0;
    else if (clk_en_i && tx_empty && !busy_ff)
      repeat_eff_ff <= cfg_ff.underrun_repeat_select;
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i)
      rdata_o <= `REG_RESET;
    else if (clk_en_i) begin
      rdata_o <= 32'h0000_0000;
      if (rd_i) begin
        case (addr_i)
          `OFS_SERIAL_DATA:
            rdata_o <= {24'h0, rxq[rx_rp_ff[PW-1:0]]};
          `OFS_SPI_STATUS:
            rdata_o <= {28'h0, tx_empty && !busy_ff,
                        !tx_full, !rx_empty, ovf_ff};
          `OFS_TWO_WIRE_STATUS:  rdata_o <= {28'h0, tw_stat_ff};
          `OFS_TWO_WIRE_COMMAND: rdata_o <= {28'h0, cmd_ff};
          `OFS_TWO_WIRE_ACK:     rdata_o <= {31'h0, ack_ctl_ff};
          `OFS_SPI_CONFIG:       rdata_o <= {26'h0, cfg_ff};
          `OFS_CLOCK_LINEAR:     rdata_o <= {28'h0, lin_ff};
          `OFS_CLOCK_EXPONENT:   rdata_o <= {28'h0, exp_ff};
          `OFS_MODE_SELECT:      rdata_o <= {31'h0, twi_mode_ff};
          default:               rdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // FIFO storage
  genvar gi;
  generate
    for (gi = 0; gi < FIFO_DEPTH; gi++) begin : g_fifo
      always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
          txq[gi] <= 8'h00;
          rxq[gi] <= 8'h00;
        end else if (clk_en_i) begin
          if (wr_data && !tx_full && tx_wp_ff[PW-1:0] == PW'(gi))
            txq[gi] <= wdata_i[7:0];
          if (rx_push && !rx_full && rx_wp_ff[PW-1:0] == PW'(gi))
            rxq[gi] <= rx_byte;
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_wp_ff <= '0;
      tx_rp_ff <= '0;
      rx_wp_ff <= '0;
      rx_rp_ff <= '0;
      ovf_ff   <= 1'b0;
    end else if (clk_en_i) begin
      if (wr_data && !tx_full)
        tx_wp_ff <= tx_wp_ff + (PW+1)'(1);
      if (tx_pop)
        tx_rp_ff <= tx_rp_ff + (PW+1)'(1);
      if (rx_push && !rx_full)
        rx_wp_ff <= rx_wp_ff + (PW+1)'(1);
      if (rd_data && !rx_empty)
        rx_rp_ff <= rx_rp_ff + (PW+1)'(1);
      // Set wins over the clearing read
      if (rx_push && rx_full)
        ovf_ff <= 1'b1;
      else if (rd_data)
        ovf_ff <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Rate generator: half periods of (lin+1)*2^exp ticks at twice 12 MHz
  logic [4:0]  base_cnt_ff;
  logic        base_tick;
  logic [19:0] rate_cnt_ff;
  logic        half_tick;
  logic [19:0] rate_div;
  assign base_tick = base_cnt_ff == 5'(`BASE_TICK_CYCLES - 1);
  assign rate_div  = 20'({16'h0, lin_ff} + 20'h1) << exp_ff;
  // Compare with >= so a smaller divider never waits for a wrap
  assign half_tick = base_tick && rate_cnt_ff >= 20'(rate_div - 20'h1);
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      base_cnt_ff <= 5'h0;
      rate_cnt_ff <= 20'h0;
    end else if (clk_en_i) begin
      base_cnt_ff <= base_tick ? 5'h0 : base_cnt_ff + 5'h1;
      if (base_tick)
        rate_cnt_ff <= half_tick ? 20'h0 : rate_cnt_ff + 20'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // SPI engine
  logic       spi_master, start_xfer;
  logic       sck_prev_ff, sck_edge, lead_edge;
  logic [7:0] next_tx, load_val;
  assign spi_master = cfg_ff.master_select && !twi_mode_ff;
  assign start_xfer = !busy_ff && spi_master && half_tick &&
    (cfg_ff.rx_driven_select ? !rx_full
                             : !tx_empty);
  // Slave edges come from the sampled external clock
  assign sck_edge  = spi_master ? half_tick : (sck_i != sck_prev_ff);
  // Leading edge toggles away from idle level
  assign lead_edge = spi_master ? !phase_ff
                   : (sck_i != cfg_ff.clock_polarity_select);
  assign next_tx = tx_empty ? (repeat_eff_ff ? last_ff : `BUSY_TOKEN)
                            : txq[tx_rp_ff[PW-1:0]];
  assign load_val = next_tx;
  assign tx_pop  = (start_xfer ||
                    (!spi_master && !twi_mode_ff && !busy_ff && !sel_n_i))
                   && !tx_empty;
  assign rx_byte = sh_in_ff;
  logic rx_push_ff;
  assign rx_push = rx_push_ff;

  function automatic logic out_bit(input logic [7:0] v, input logic lsb);
    out_bit = lsb ? v[0] : v[7];
  endfunction

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_ff     <= 1'b0;
      sh_out_ff   <= 8'h00;
      sh_in_ff    <= 8'h00;
      last_ff     <= 8'h00;
      bit_cnt_ff  <= 4'h0;
      phase_ff    <= 1'b0;
      sck_prev_ff <= 1'b0;
      rx_push_ff  <= 1'b0;
      sck_o       <= 1'b0;
      mosi_o      <= 1'b0;
      miso_o      <= 1'b0;
    end else if (clk_en_i) begin
      sck_prev_ff <= sck_i;
      rx_push_ff  <= 1'b0;
      if (!busy_ff) begin
        sck_o <= cfg_ff.clock_polarity_select;
        if (start_xfer || (!spi_master && !twi_mode_ff && !sel_n_i)) begin
          busy_ff    <= 1'b1;
          sh_out_ff  <= load_val;
          last_ff    <= load_val;
          bit_cnt_ff <= 4'h0;
          phase_ff   <= 1'b0;
          mosi_o     <= out_bit(load_val, cfg_ff.bit_order_select);
          miso_o     <= out_bit(load_val, cfg_ff.bit_order_select);
        end
      end else if (!spi_master && sel_n_i) begin
        busy_ff <= 1'b0;
      end else if (sck_edge) begin
        if (spi_master) begin
          sck_o    <= ~sck_o;
          phase_ff <= ~phase_ff;
        end
        // Sample on leading edge unless phase set
        if (lead_edge != cfg_ff.clock_phase_select) begin
          sh_in_ff <= cfg_ff.bit_order_select
                    ? {(spi_master ? miso_i : mosi_i), sh_in_ff[7:1]}
                    : {sh_in_ff[6:0], (spi_master ? miso_i : mosi_i)};
          bit_cnt_ff <= bit_cnt_ff + 4'h1;
          if (bit_cnt_ff == 4'h7) begin
            rx_push_ff <= 1'b1;
            // Leading-edge sampling still owes the trailing half period
            if (cfg_ff.clock_phase_select)
              busy_ff <= 1'b0;
          end
        end else if (bit_cnt_ff == 4'h8) begin
          busy_ff <= 1'b0;
        end else if (bit_cnt_ff != 4'h0) begin
          sh_out_ff <= cfg_ff.bit_order_select
                     ? {1'b0, sh_out_ff[7:1]} : {sh_out_ff[6:0], 1'b0};
          mosi_o <= cfg_ff.bit_order_select ? sh_out_ff[1] : sh_out_ff[6];
          miso_o <= cfg_ff.bit_order_select ? sh_out_ff[1] : sh_out_ff[6];
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sck_oe_o  <= 1'b0;
      mosi_oe_o <= 1'b0;
      miso_oe_o <= 1'b0;
    end else if (clk_en_i) begin
      sck_oe_o  <= spi_master;
      mosi_oe_o <= spi_master;
      miso_oe_o <= !cfg_ff.master_select && !twi_mode_ff && !sel_n_i;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Two-wire master sequencer; one command at a time assumed
  twi_state_t tw_state_ff;
  logic [1:0] tw_q_ff;
  logic [3:0] tw_bit_ff;
  logic [7:0] tw_sh_ff;
  logic       tw_owned_ff;
  logic       tw_go;
  assign tw_go = twi_mode_ff && half_tick;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tw_state_ff <= TW_IDLE;
      tw_q_ff     <= 2'h0;
      tw_bit_ff   <= 4'h0;
      tw_sh_ff    <= 8'h00;
      tw_owned_ff <= 1'b0;
      cmd_ff      <= 4'h0;
      tw_stat_ff  <= '0;
      scl_oe_o    <= 1'b0;
      sda_oe_o    <= 1'b0;
    end else if (clk_en_i) begin
      if (wr_i && addr_i == `OFS_TWO_WIRE_COMMAND && tw_state_ff == TW_IDLE)
        cmd_ff <= wdata_i[3:0];
      if (tw_go) begin
        tw_q_ff <= tw_q_ff + 2'h1;
        case (tw_state_ff)
          TW_IDLE: begin
            tw_q_ff <= 2'h0;
            if (cmd_ff != 4'h0)
              tw_stat_ff <= '0;
            if (cmd_ff[`CMD_START])
              tw_state_ff <= TW_START;
            else if (cmd_ff[`CMD_STOP])
              tw_state_ff <= TW_STOP;
            else if (cmd_ff[`CMD_SEND] || cmd_ff[`CMD_RECV]) begin
              tw_state_ff <= TW_BYTE;
              tw_bit_ff   <= 4'h0;
              tw_sh_ff    <= cmd_ff[`CMD_SEND] ? txq[tx_rp_ff[PW-1:0]]
                                               : 8'h00;
            end
          end
          // Quarter steps: release SDA, release SCL, pull SDA, pull SCL
          TW_START: begin
            case (tw_q_ff)
              2'h0: sda_oe_o <= 1'b0;
              2'h1: scl_oe_o <= 1'b0;
              2'h2: sda_oe_o <= 1'b1;
              default: begin
                scl_oe_o    <= 1'b1;
                tw_owned_ff <= 1'b1;
                tw_state_ff <= TW_DONE;
              end
            endcase
          end
          TW_STOP: begin
            case (tw_q_ff)
              2'h0: sda_oe_o <= 1'b1;
              2'h1: scl_oe_o <= 1'b0;
              2'h2: sda_oe_o <= 1'b0;
              default: begin
                tw_owned_ff <= 1'b0;
                tw_state_ff <= TW_DONE;
              end
            endcase
          end
          TW_BYTE, TW_ACK: begin
            case (tw_q_ff)
              2'h0: sda_oe_o <= (tw_state_ff == TW_ACK)
                       ? (cmd_ff[`CMD_RECV] && ack_ctl_ff)
                       : (cmd_ff[`CMD_SEND] && !tw_sh_ff[7]);
              2'h1: scl_oe_o <= 1'b0;
              2'h2: begin
                if (tw_state_ff == TW_BYTE)
                  tw_sh_ff <= {tw_sh_ff[6:0], sda_i};
                else if (cmd_ff[`CMD_SEND] && sda_i)
                  tw_stat_ff.nack_received_flag <= 1'b1;
              end
              default: begin
                scl_oe_o  <= 1'b1;
                tw_bit_ff <= tw_bit_ff + 4'h1;
                if (tw_state_ff == TW_ACK)
                  tw_state_ff <= TW_DONE;
                else if (tw_bit_ff == 4'h7)
                  tw_state_ff <= TW_ACK;
              end
            endcase
          end
          TW_DONE: begin
            if (cmd_ff[`CMD_START] || cmd_ff[`CMD_STOP])
              tw_stat_ff.command_finished_flag <= 1'b1;
            if (cmd_ff[`CMD_RECV])
              tw_stat_ff.receive_finished_flag <= 1'b1;
            if (cmd_ff[`CMD_SEND])
              tw_stat_ff.transmit_finished_flag <= 1'b1;
            cmd_ff      <= 4'h0;
            tw_state_ff <= TW_IDLE;
          end
          default: tw_state_ff <= TW_IDLE;
        endcase
      end
    end
  end
endmodule // serial_ctrl

// file: testbench/serial_ctrl_monitor.sv
// Port-level assertions for the serial controller
`timescale 1ns/1ps
module serial_ctrl_monitor (
  input wire logic        sys_clk_i,
  input wire logic        rst_i,
  input wire logic [15:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic        sck_o,
  input wire logic        mosi_oe_o,
  input wire logic        miso_oe_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////////
  a_read_quiet: assert property (
    !$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data not zero outside a read answer");
  a_data_width: assert property (
    rd_i && addr_i == 16'hC83C |=> rdata_o[31:8] == 24'h0)
    else $error("data read shows bits above the byte");
  a_status_upper: assert property (
    rd_i && addr_i == 16'hC840 |=> rdata_o[31:4] == 28'h0)
    else $error("spi status reserved bits set");
  a_twi_upper: assert property (
    rd_i && addr_i == 16'hC844 |=> rdata_o[31:4] == 28'h0)
    else $error("two-wire status reserved bits set");
  a_cfg_readback: assert property (
    wr_i && addr_i == 16'hC858 ##1 rd_i && addr_i == 16'hC858
    |=> rdata_o == {26'h0, $past(wdata_i[5:0], 2)})
    else $error("spi config readback differs from write");
  a_rate_readback: assert property (
    wr_i && addr_i == 16'hC860 ##1 rd_i && addr_i == 16'hC860
    |=> rdata_o == {28'h0, $past(wdata_i[3:0], 2)})
    else $error("linear prescale readback differs");
  // Fastest serial clock holds each half period for 8 cycles
  a_sck_half: assert property (
    $changed(sck_o) |=> $stable(sck_o) [*7])
    else $error("serial clock toggled too fast");
  a_oe_exclusive: assert property (
    !(mosi_oe_o && miso_oe_o))
    else $error("master and slave data outputs both enabled");
endmodule // serial_ctrl_monitor

bind serial_ctrl serial_ctrl_monitor mon (
  .sys_clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .sck_o,
  .mosi_oe_o, .miso_oe_o);

// file: testbench/spi_far_end.sv
// Far-end SPI slave model: mode 0, most significant bit first
`timescale 1ns/1ps
module spi_far_end (
  input  wire logic       sck_i,
  input  wire logic       mosi_i,
  input  wire logic [7:0] reply_i,
  output logic            miso_o,
  output logic [7:0]      got_o
);
  logic [2:0] cnt_ff = 3'h0;
  logic       bit_ff = 1'b0;
  initial got_o = 8'h00;
  // First bit must wait on the line before the leading edge
  assign miso_o = (cnt_ff == 3'h0) ? reply_i[7] : bit_ff;
  always @(posedge sck_i) begin
    got_o  <= {got_o[6:0], mosi_i};
    cnt_ff <= cnt_ff + 3'h1;
  end
  always @(negedge sck_i) begin
    bit_ff <= reply_i[3'h7 - cnt_ff];
  end
endmodule // spi_far_end

// file: testbench/serial_ctrl_tb.sv
// Self-checking bench for the serial controller
`timescale 1ns/1ps
module serial_ctrl_tb;
  typedef struct packed {
    logic        w;
    logic [15:0] a;
    logic [31:0] d;
    logic [31:0] e;
  } row_t;
  logic        sys_clk_i = 1'b0;
  logic        rst_i     = 1'b1;
  logic [15:0] addr_i    = 16'h0;
  logic [31:0] wdata_i   = 32'h0;
  logic        wr_i      = 1'b0;
  logic        rd_i      = 1'b0;
  logic [31:0] rdata_o;
  logic        sck_o, sck_oe_o, mosi_o, mosi_oe_o, miso_i;
  logic        miso_o, miso_oe_o, scl_oe_o, sda_oe_o;
  logic [7:0]  got, q0, q1;
  logic        en      = 1'b1;
  logic        sck_s   = 1'b0;
  logic        mosi_s  = 1'b0;
  logic        sel_n_s = 1'b1;
  logic [31:0] v;
  logic [31:0] cmd [4] = '{32'h4, 32'h2, 32'h1, 32'h8};
  logic [31:0] fin [4] = '{32'h8, 32'h3, 32'h4, 32'h8};
  int          err_count  = 0;
  int          n_compared = 0;
  row_t        rows [15];
  always #2.5 sys_clk_i = ~sys_clk_i;
  // Two-wire lines: pull-ups only, so every address byte is refused
  serial_ctrl dut (
    .sys_clk_i, .rst_i, .clk_en_i(en), .addr_i, .wdata_i, .wr_i,
    .rd_i, .rdata_o, .sck_i(sck_s), .sck_o, .sck_oe_o, .mosi_o,
    .mosi_oe_o, .miso_i, .miso_o, .miso_oe_o, .mosi_i(mosi_s),
    .sel_n_i(sel_n_s), .scl_i(~scl_oe_o), .scl_oe_o, .sda_i(~sda_oe_o),
    .sda_oe_o);
  spi_far_end peer (.sck_i(sck_o), .mosi_i(mosi_o), .reply_i(8'hA5),
    .miso_o(miso_i), .got_o(got));
  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    if (err_count == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got_v, input logic [31:0] exp_v);
    n_compared++;
    if (got_v !== exp_v) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got_v, exp_v);
    end
  endtask
  // Strobe left high on purpose so a read can follow with no gap
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    addr_i  <= a;
    wdata_i <= d;
    {wr_i, rd_i} <= 2'b10;
    @(posedge sys_clk_i);
  endtask
  task automatic rd(input logic [15:0] a, output logic [31:0] q);
    addr_i <= a;
    {wr_i, rd_i} <= 2'b01;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1 q = rdata_o;
    @(posedge sys_clk_i);
  endtask
  // Bench as SPI master, mode 0, most significant bit first
  task automatic slave_byte(input logic [7:0] m, output logic [7:0] q);
    for (int b = 7; b >= 0; b--) begin
      mosi_s <= m[b];
      repeat (4) @(posedge sys_clk_i);
      sck_s <= 1'b1;
      q[b] = miso_o;
      repeat (4) @(posedge sys_clk_i);
      sck_s <= 1'b0;
    end
    repeat (4) @(posedge sys_clk_i);
  endtask
  task automatic poll(input logic [15:0] a, input logic [31:0] m,
                      input logic [31:0] e);
    for (int i = 0; i < 3000; i++) begin
      rd(a, v);
      if ((v & m) === e) break;
    end
    chk(v & m, e);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    // Polarity kept low: the far-end model has no select to resync on
    rows = '{'{1'b0, 16'hC83C, 32'h0, 32'h0},
             '{1'b0, 16'hC840, 32'h0, 32'hC},
             '{1'b0, 16'hC844, 32'h0, 32'h0},
             '{1'b0, 16'hC84C, 32'h0, 32'h0},
             '{1'b0, 16'hC850, 32'h0, 32'h0},
             '{1'b0, 16'hC858, 32'h0, 32'h0},
             '{1'b0, 16'hC860, 32'h0, 32'h0},
             '{1'b0, 16'hC864, 32'h0, 32'h0},
             '{1'b0, 16'hC848, 32'h0, 32'h0},
             '{1'b1, 16'hC858, 32'hFFFFFFEE, 32'h2E},
             '{1'b1, 16'hC860, 32'hF, 32'hF},
             '{1'b1, 16'hC864, 32'h3, 32'h3},
             '{1'b1, 16'hC850, 32'h1, 32'h1},
             '{1'b1, 16'hC848, 32'hFF, 32'h0},
             '{1'b1, 16'hC840, 32'hFF, 32'hC}};
    repeat (5) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      rd(rows[i].a, v);
      chk(v, rows[i].e);
    end
    wr(16'hC860, 32'h0);
    wr(16'hC864, 32'h0);
    wr(16'hC858, 32'h10);
    wr(16'hC83C, 32'h3C);
    poll(16'hC840, 32'hA, 32'hA);
    chk({24'h0, got}, 32'h3C);
    rd(16'hC83C, v);
    chk(v, 32'hA5);
    for (int i = 0; i < 4; i++) wr(16'hC83C, 32'h11 * i);
    poll(16'hC840, 32'hF, 32'hE);
    wr(16'hC83C, 32'h55);
    poll(16'hC840, 32'hF, 32'hF);
    rd(16'hC83C, v);
    chk(v, 32'hA5);
    rd(16'hC840, v);
    chk(v, 32'hE);
    repeat (3) rd(16'hC83C, v);
    rd(16'hC840, v);
    chk(v, 32'hC);
    // Transfers driven by receive space alone, with nothing to send
    wr(16'hC858, 32'h30);
    poll(16'hC840, 32'h2, 32'h2);
    wr(16'hC858, 32'h10);
    poll(16'hC840, 32'h8, 32'h8);
    repeat (4) rd(16'hC83C, v);
    // Two-wire mode: the send byte comes from the transmit queue head
    wr(16'hC868, 32'h1);
    wr(16'hC83C, 32'h5A);
    foreach (cmd[i]) begin
      wr(16'hC84C, cmd[i]);
      poll(16'hC84C, 32'hF, 32'h0);
      rd(16'hC844, v);
      chk(v, fin[i]);
    end
    chk({30'h0, scl_oe_o, sda_oe_o}, 32'h0);
    // Slave mode: queued byte first, then the underrun token
    wr(16'hC858, 32'h0);
    wr(16'hC868, 32'h0);
    rd(16'hC840, v);
    chk(v, 32'h4);
    sel_n_s <= 1'b0;
    slave_byte(8'hC3, q0);
    slave_byte(8'h96, q1);
    sel_n_s <= 1'b1;
    chk({24'h0, q0}, 32'h5A);
    chk({24'h0, q1}, 32'hFF);
    rd(16'hC83C, v);
    chk(v, 32'hC3);
    // A write with the clock enable low must be lost
    en <= 1'b0;
    wr(16'hC864, 32'h5);
    en <= 1'b1;
    rd(16'hC864, v);
    chk(v, 32'h0);
    final_report();
  end
  initial begin
    repeat (80000) @(posedge sys_clk_i);
    err_count++;
    final_report();
  end
endmodule // serial_ctrl_tb
